// *** design/int_pipeline.sv ***
// Five-stage integer pipeline: fetch, read, execute, data, write-back.
// Assumes a synchronous instruction memory and a data memory read combinationally, both on the same clock,
// translation is identity; the instruction arrives during the read stage.
`timescale 1ns/1ps
`default_nettype none
module int_pipeline
    import pipe_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        MCLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        CE_IN,
    // Instruction side
    output logic [63:0]      IADDR_OUT,
    input  wire logic [31:0] INSTR_IN,
    // Data side
    output logic [63:0]      DADDR_OUT,
    output logic [63:0]      DWDATA_OUT,
    output logic [7:0]       DBE_OUT,
    output logic             DWE_OUT,
    output logic             DRE_OUT,
    input  wire logic [63:0] DRDATA_IN,
    // Status
    output logic             SLIP_OUT
);
    logic [63:0] rf [NREG];
    logic [63:0] pc_q, r_pc_q;
    logic        r_vld_q;
    logic        a_vld_q, d_vld_q, w_vld_q, a_wr_q, d_wr_q, w_wr_q;
    op_e         a_op_q, d_op_q;
    logic [4:0]  a_rd_q, d_rd_q, w_rd_q;
    logic [63:0] a_sv_q, a_tv_q, a_imm_q, a_tgt_q;
    byp_e        a_ss_q, a_ts_q;
    logic [63:0] d_res_q, d_wdata_q, w_res_q;
    logic [7:0]  d_be_q;
    logic [63:0] muldiv_high_result, muldiv_low_result;
    logic [6:0]  md_cnt_q;
    function automatic logic writes_rd(input op_e op);
        return !(op inside {OP_SD, OP_SW, OP_BEQ, OP_MUL32, OP_MUL64, OP_DIV32, OP_DIV64});
    endfunction
    // Read stage decode
    op_e         r_op;
    logic [4:0]  r_rd, r_rs, r_rt;
    logic [63:0] r_imm, r_sv, r_tv, r_tgt;
    byp_e        r_ss, r_ts;
    logic        w_we;
    assign r_op  = op_e'(INSTR_IN[31:OP_LSB]);
    assign r_rd  = INSTR_IN[RD_LSB+:5];
    assign r_rs  = INSTR_IN[RS_LSB+:5];
    assign r_rt  = INSTR_IN[RT_LSB+:5];
    assign r_imm = {{52{INSTR_IN[IMM_MSB]}}, INSTR_IN[IMM_MSB:0]};
    assign r_tgt = r_pc_q + PC_STEP + {r_imm[61:0], 2'b00};
    assign w_we  = w_vld_q && w_wr_q && (w_rd_q != 5'h00);
    function automatic byp_e byp_sel(input logic [4:0] src);
        if (src == 5'h00) return BYP_RF;
        else if (a_vld_q && a_wr_q && a_rd_q == src) return BYP_D;
        else if (d_vld_q && d_wr_q && d_rd_q == src) return BYP_W;
        else return BYP_RF;
    endfunction
    // Two read ports with write-through
    assign r_sv = (r_rs == 5'h00) ? 64'h0 : (w_we && w_rd_q == r_rs) ? w_res_q : rf[r_rs];
    assign r_tv = (r_rt == 5'h00) ? 64'h0 : (w_we && w_rd_q == r_rt) ? w_res_q : rf[r_rt];
    // Bypass select follows later-stage state read inside the function
    always_comb begin
        r_ss = byp_sel(r_rs);
        r_ts = byp_sel(r_rt);
    end
    // Execute stage operands, issue decision
    logic [63:0] opa, opb, a_res, st_data;
    logic [7:0]  st_be;
    logic        ld_haz, md_haz, slip, br_take, md_start;
    assign opa = (a_ss_q == BYP_D) ? d_res_q : (a_ss_q == BYP_W) ? w_res_q : a_sv_q;
    assign opb = (a_ts_q == BYP_D) ? d_res_q : (a_ts_q == BYP_W) ? w_res_q : a_tv_q;
    assign ld_haz = d_vld_q && (d_op_q inside {OP_LD, OP_LW})
                    && (a_ss_q == BYP_D || a_ts_q == BYP_D);
    assign md_haz = (md_cnt_q != 7'h00)
                    && (a_op_q inside {OP_MOVE_FROM_HIGH_RESULT, OP_MOVE_FROM_LOW_RESULT, OP_MUL32, OP_MUL64, OP_DIV32, OP_DIV64});
    assign slip     = a_vld_q && (ld_haz || md_haz);
    assign SLIP_OUT = slip;
    assign br_take  = a_vld_q && !slip && a_op_q == OP_BEQ && opa == opb;
    assign md_start = a_vld_q && !slip && (a_op_q inside {OP_MUL32, OP_MUL64, OP_DIV32, OP_DIV64});
    // Adder and logic unit, single cycle
    always_comb begin
        case (a_op_q)
            OP_ADD:  a_res = opa + opb;
            OP_SUB:  a_res = opa - opb;
            OP_AND:  a_res = opa & opb;
            OP_OR:   a_res = opa | opb;
            OP_XOR:  a_res = opa ^ opb;
            OP_SLL:  a_res = opa << opb[5:0];
            OP_SRL:  a_res = opa >> opb[5:0];
            OP_MOVE_FROM_HIGH_RESULT: a_res = muldiv_high_result;
            OP_MOVE_FROM_LOW_RESULT: a_res = muldiv_low_result;
            default: a_res = opa + a_imm_q;
        endcase
    end
    // Store align
    always_comb begin
        if (a_op_q == OP_SW) begin
            st_data = {opb[31:0], opb[31:0]};
            st_be   = a_res[2] ? 8'hF0 : 8'h0F;
        end else begin
            st_data = opb;
            st_be   = 8'hFF;
        end
    end
    // Fetch and read stage registers
    assign IADDR_OUT = slip ? r_pc_q : pc_q;
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pc_q    <= PC_RESET;
            r_pc_q  <= PC_RESET;
            r_vld_q <= 1'b0;
        end else if (CE_IN && !slip) begin
            pc_q    <= br_take ? a_tgt_q : pc_q + PC_STEP;
            r_pc_q  <= pc_q;
            r_vld_q <= !br_take;
        end
    end
    // Execute stage registers; held on slip with bypass retargeted
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            a_vld_q <= 1'b0;
            a_wr_q  <= 1'b0;
            a_op_q  <= OP_ADD;
            a_rd_q  <= 5'h00;
            a_sv_q  <= 64'h0;
            a_tv_q  <= 64'h0;
            a_imm_q <= 64'h0;
            a_tgt_q <= 64'h0;
            a_ss_q  <= BYP_RF;
            a_ts_q  <= BYP_RF;
        end else if (CE_IN) begin
            if (slip) begin
                if (a_ss_q == BYP_W) a_sv_q <= w_res_q;
                if (a_ts_q == BYP_W) a_tv_q <= w_res_q;
                a_ss_q <= (a_ss_q == BYP_D) ? BYP_W : BYP_RF;
                a_ts_q <= (a_ts_q == BYP_D) ? BYP_W : BYP_RF;
            end else begin
                a_vld_q <= r_vld_q;
                a_wr_q  <= writes_rd(r_op) && (r_rd != 5'h00);
                a_op_q  <= r_op;
                a_rd_q  <= r_rd;
                a_sv_q  <= r_sv;
                a_tv_q  <= r_tv;
                a_imm_q <= r_imm;
                a_tgt_q <= r_tgt;
                a_ss_q  <= r_ss;
                a_ts_q  <= r_ts;
            end
        end
    end
    // Data stage: slip inserts a bubble, older work moves on
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            d_vld_q   <= 1'b0;
            d_wr_q    <= 1'b0;
            d_op_q    <= OP_ADD;
            d_rd_q    <= 5'h00;
            d_res_q   <= 64'h0;
            d_wdata_q <= 64'h0;
            d_be_q    <= 8'h00;
        end else if (CE_IN) begin
            d_vld_q   <= a_vld_q && !slip;
            d_wr_q    <= a_wr_q;
            d_op_q    <= a_op_q;
            d_rd_q    <= a_rd_q;
            d_res_q   <= a_res;
            d_wdata_q <= st_data;
            d_be_q    <= st_be;
        end
    end
    assign DADDR_OUT  = d_res_q;
    assign DWDATA_OUT = d_wdata_q;
    assign DBE_OUT    = d_be_q;
    assign DWE_OUT    = d_vld_q && (d_op_q inside {OP_SD, OP_SW});
    assign DRE_OUT    = d_vld_q && (d_op_q inside {OP_LD, OP_LW});
    // Load align and write-back
    logic [63:0] ld_val;
    logic [31:0] ld_word;
    assign ld_word = d_res_q[2] ? DRDATA_IN[63:32] : DRDATA_IN[31:0];
    assign ld_val  = (d_op_q == OP_LW) ? {{32{ld_word[31]}}, ld_word} : DRDATA_IN;
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            w_vld_q <= 1'b0;
            w_wr_q  <= 1'b0;
            w_rd_q  <= 5'h00;
            w_res_q <= 64'h0;
        end else if (CE_IN) begin
            w_vld_q <= d_vld_q;
            w_wr_q  <= d_wr_q;
            w_rd_q  <= d_rd_q;
            w_res_q <= DRE_OUT ? ld_val : d_res_q;
        end
    end
    // Register file, r0 stays zero
    always_ff @(posedge MCLK_IN) begin
        if (CE_IN && w_we) rf[w_rd_q] <= w_res_q;
    end
    // Multiply/divide unit and result pair
    logic [127:0] prod64;
    logic [63:0]  prod32;
    logic [63:0]  md_hi, md_lo;
    logic [6:0]   md_lat;
    assign prod64 = $signed(opa) * $signed(opb);
    assign prod32 = $signed(opa[31:0]) * $signed(opb[31:0]);
    always_comb begin
        md_hi  = 64'h0;
        md_lo  = 64'h0;
        md_lat = DIV64_CYC;
        case (a_op_q)
            OP_MUL32: begin
                md_hi  = {{32{prod32[63]}}, prod32[63:32]};
                md_lo  = {{32{prod32[31]}}, prod32[31:0]};
                md_lat = (opb[31:16] == 16'h0) ? MUL32_MIN_CYC : MUL32_MAX_CYC;
            end
            OP_MUL64: begin
                md_hi  = prod64[127:64];
                md_lo  = prod64[63:0];
                md_lat = (opb[63:16] == 48'h0) ? MUL64_MIN_CYC : MUL64_MAX_CYC;
            end
            OP_DIV32: begin
                if (opb[31:0] != 32'h0) begin
                    md_lo = 64'($signed(32'($signed(opa[31:0]) / $signed(opb[31:0]))));
                    md_hi = 64'($signed(32'($signed(opa[31:0]) % $signed(opb[31:0]))));
                end
                md_lat = DIV32_CYC;
            end
            default: begin
                if (opb != 64'h0) begin
                    md_lo = $signed(opa) / $signed(opb);
                    md_hi = $signed(opa) % $signed(opb);
                end
                md_lat = DIV64_CYC;
            end
        endcase
    end
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            md_cnt_q           <= 7'h00;
            muldiv_high_result <= 64'h0;
            muldiv_low_result  <= 64'h0;
        end else if (CE_IN) begin
            if (md_start) begin
                md_cnt_q           <= md_lat;
                muldiv_high_result <= md_hi;
                muldiv_low_result  <= md_lo;
            end else if (md_cnt_q != 7'h00) begin
                md_cnt_q <= md_cnt_q - 7'h01;
            end
        end
    end
    // Checks
    sequence s_div64_issue;
        CE_IN && md_start && a_op_q == OP_DIV64;
    endsequence
    sequence s_mul32_fast;
        CE_IN && md_start && a_op_q == OP_MUL32 && opb[31:16] == 16'h0;
    endsequence
    property p_wb_write;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) CE_IN && w_we |=> rf[$past(w_rd_q)] == $past(w_res_q);
    endproperty
    a_wb_write: assert property (p_wb_write) else $error("write-back lost");
    property p_slip_hold;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) CE_IN && slip |=> a_vld_q && $stable(a_op_q) && !d_vld_q;
    endproperty
    a_slip_hold: assert property (p_slip_hold) else $error("slip did not hold");
    property p_fetch_step;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) CE_IN && !slip && !br_take |=> pc_q == $past(pc_q) + PC_STEP;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("fetch did not advance");
    property p_branch;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) CE_IN && br_take |=> !r_vld_q && pc_q == $past(a_tgt_q);
    endproperty
    a_branch: assert property (p_branch) else $error("branch redirect wrong");
    property p_mul32;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) s_mul32_fast |=> md_cnt_q == MUL32_MIN_CYC;
    endproperty
    a_mul32: assert property (p_mul32) else $error("multiply latency wrong");
    property p_div64;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) s_div64_issue |=> md_cnt_q == DIV64_CYC;
    endproperty
    a_div64: assert property (p_div64) else $error("divide latency wrong");
    property p_move_lock;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
            d_vld_q && (d_op_q inside {OP_MOVE_FROM_HIGH_RESULT, OP_MOVE_FROM_LOW_RESULT}) |-> $past(md_cnt_q) == 7'h00;
    endproperty
    a_move_lock: assert property (p_move_lock) else $error("move did not interlock");
    property p_md_count;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
            CE_IN && !md_start && md_cnt_q != 7'h00 |=> md_cnt_q == $past(md_cnt_q) - 7'h01;
    endproperty
    a_md_count: assert property (p_md_count) else $error("muldiv count stuck");
    property p_pass_on;
        @(posedge MCLK_IN) disable iff (!RSTN_IN) CE_IN && d_vld_q |=> w_vld_q;
    endproperty
    a_pass_on: assert property (p_pass_on) else $error("older work stalled");
endmodule
`default_nettype wire

// *** design/pipe_pkg.sv ***
// Constants, opcodes and timing of the five-stage integer pipeline.
// Assumes one processor clock; each stage takes one cycle split in two phases.
// Notes on behaviour
// - Instructions pass through five stages, each made of a first and second phase.
// - Instruction cache access runs from first fetch phase to first read phase, translation in second fetch phase.
// - In the second read phase the register file is read, bypass chosen, decode done and branch target formed.
// - In the first execute phase issue or slip and branch are decided and the data address formed; ALU spans execute.
// - Store data is aligned in execute; data cache access and load align run from second execute to second data phase.
// - Data translation happens in the first data phase, joint translation across both data phases.
// - Results are written to the register file in the second write-back phase.
// - There are thirty-two 64-bit general registers plus a program counter.
// - The register file has two read ports, one write port and full bypass.
// - The adder does arithmetic and addresses, the logic unit logic and shifts, each in one cycle.
// - Multiply and divide put results in a separate high and low result pair.
// - Move instructions copy the high or low result into a general register.
// - Multiply takes 6 to 9 cycles for 32-bit and 7 to 10 for 64-bit; an earlier move interlocks.
// - Divide takes 42 cycles for 32-bit and 74 for 64-bit operands.
package pipe_pkg;
    localparam int          XLEN          = 64;
    localparam int          NREG          = 32;
    localparam logic [63:0] PC_RESET      = 64'h0000_0000_0000_0000;
    localparam logic [63:0] PC_STEP       = 64'h0000_0000_0000_0004;
    // Instruction word fields
    localparam int          OP_LSB        = 27;
    localparam int          RD_LSB        = 22;
    localparam int          RS_LSB        = 17;
    localparam int          RT_LSB        = 12;
    localparam int          IMM_MSB       = 11;
    // Multiply/divide latencies in cycles
    localparam logic [6:0]  MUL32_MIN_CYC = 7'h06;
    localparam logic [6:0]  MUL32_MAX_CYC = 7'h09;
    localparam logic [6:0]  MUL64_MIN_CYC = 7'h07;
    localparam logic [6:0]  MUL64_MAX_CYC = 7'h0A;
    localparam logic [6:0]  DIV32_CYC     = 7'h2A;
    localparam logic [6:0]  DIV64_CYC     = 7'h4A;

    typedef enum logic [4:0] {
        OP_ADD   = 5'h00, OP_SUB  = 5'h01, OP_AND  = 5'h02, OP_OR   = 5'h03,
        OP_XOR   = 5'h04, OP_SLL  = 5'h05, OP_SRL  = 5'h06, OP_ADDI = 5'h07,
        OP_LD    = 5'h08, OP_SD   = 5'h09, OP_LW   = 5'h0A, OP_SW   = 5'h0B,
        OP_BEQ   = 5'h0C, OP_MUL32 = 5'h0D, OP_MUL64 = 5'h0E, OP_DIV32 = 5'h0F,
        OP_DIV64 = 5'h10, OP_MOVE_FROM_HIGH_RESULT = 5'h11, OP_MOVE_FROM_LOW_RESULT = 5'h12
    } op_e;

    typedef enum logic [1:0] {
        BYP_RF = 2'h0,
        BYP_D  = 2'h1,
        BYP_W  = 2'h3
    } byp_e;
endpackage

// *** sim/five_stage_integer_pipeline_tb_top.sv ***
// Self-checking bench for the integer pipeline: runs small programs from a bench memory.
// Assumes pipe_pkg and int_pipeline compiled first; one 50 MHz clock, no other parties.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) \
    begin n_tests++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH %s expected %h seen %h", name, exp, got); end end
module five_stage_integer_pipeline_tb_top;
    import pipe_pkg::*;

    logic        mclk;
    logic        rstn;
    logic        ce;
    logic [63:0] iaddr;
    logic [31:0] instr;
    logic [63:0] daddr;
    logic [63:0] dwdata;
    logic [7:0]  dbe;
    logic        dwe;
    logic        dre;
    logic [63:0] drdata;
    logic        slip;
    logic [31:0] imem [0:63];
    logic [63:0] dmem [0:63];
    int          err_count = 0;
    int          n_tests   = 0;

    int_pipeline dut_u (
        .MCLK_IN    (mclk),
        .RSTN_IN    (rstn),
        .CE_IN      (ce),
        .IADDR_OUT  (iaddr),
        .INSTR_IN   (instr),
        .DADDR_OUT  (daddr),
        .DWDATA_OUT (dwdata),
        .DBE_OUT    (dbe),
        .DWE_OUT    (dwe),
        .DRE_OUT    (dre),
        .DRDATA_IN  (drdata),
        .SLIP_OUT   (slip)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Instruction word one enabled cycle after its address; stores land at the edge
    always @(posedge mclk) begin
        if (ce === 1'b1)
            instr <= imem[iaddr[7:2]];
        if (ce === 1'b1 && dwe === 1'b1)
            for (int b = 0; b < 8; b++)
                if (dbe[b]) dmem[daddr[8:3]][8*b +: 8] <= dwdata[8*b +: 8];
    end
    assign drdata = dmem[daddr[8:3]];

    function automatic logic [31:0] enc(input op_e op, input int rd, input int rs,
                                        input int rt, input int imm);
        return {op, 5'(rd), 5'(rs), 5'(rt), 12'(imm)};
    endfunction

    task automatic clear_mem;
        for (int i = 0; i < 64; i++) begin
            imem[i] = 32'h0000_0000;
            dmem[i] = 64'h0;
        end
    endtask

    task automatic do_reset;
        @(posedge mclk) rstn <= 1'b0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
    endtask

    // Runs n cycles and counts slip cycles
    task automatic run(input int n, output int slips);
        slips = 0;
        repeat (n) begin
            @(negedge mclk);
            if (slip === 1'b1) slips++;
        end
    endtask

    task automatic t_alu;
        logic [63:0] exp [0:6] = '{64'h8, 64'h3, 64'h0, 64'hD, 64'hB, 64'h28, 64'h1};
        int          s;
        clear_mem;
        imem[0] = enc(OP_ADDI, 1, 0, 0, 5);
        imem[1] = enc(OP_ADDI, 2, 1, 0, 3);
        imem[2] = enc(OP_SUB, 3, 2, 1, 0);
        imem[3] = enc(OP_AND, 4, 2, 1, 0);
        imem[4] = enc(OP_OR, 5, 2, 1, 0);
        imem[5] = enc(OP_XOR, 6, 2, 3, 0);
        imem[6] = enc(OP_SLL, 7, 1, 3, 0);
        imem[7] = enc(OP_SRL, 8, 2, 3, 0);
        for (int k = 0; k < 7; k++) imem[8+k] = enc(OP_SD, 0, 0, k + 2, 8 * k);
        do_reset;
        for (int k = 0; k < 4; k++) begin
            @(negedge mclk);
            `CHECK("fetch address", 64'(4 * k), iaddr)
        end
        run(30, s);
        for (int k = 0; k < 7; k++) `CHECK("alu result", exp[k], dmem[k])
        `CHECK("alu slips", 0, s)
    endtask

    task automatic t_load;
        int s;
        clear_mem;
        imem[0] = enc(OP_ADDI, 1, 0, 0, -2);
        imem[1] = enc(OP_SD, 0, 0, 1, 'h40);
        imem[2] = enc(OP_LD, 2, 0, 0, 'h40);
        imem[3] = enc(OP_ADD, 3, 2, 2, 0);
        imem[4] = enc(OP_SD, 0, 0, 3, 'h48);
        imem[5] = enc(OP_LW, 4, 0, 0, 'h44);
        imem[6] = enc(OP_SD, 0, 0, 4, 'h50);
        imem[7] = enc(OP_SW, 0, 0, 1, 'h5C);
        do_reset;
        run(30, s);
        `CHECK("stored word", 64'hFFFF_FFFF_FFFF_FFFE, dmem[8])
        `CHECK("load-use sum", 64'hFFFF_FFFF_FFFF_FFFC, dmem[9])
        `CHECK("word load", 64'hFFFF_FFFF_FFFF_FFFF, dmem[10])
        `CHECK("word store", 64'hFFFF_FFFE_0000_0000, dmem[11])
        `CHECK("load-use slips", 2, s)
    endtask

    task automatic t_muldiv;
        int s;
        clear_mem;
        imem[0] = enc(OP_ADDI, 1, 0, 0, 7);
        imem[1] = enc(OP_ADDI, 2, 0, 0, 3);
        imem[2] = enc(OP_MUL32, 0, 1, 2, 0);
        imem[3] = enc(OP_MOVE_FROM_LOW_RESULT, 3, 0, 0, 0);
        imem[4] = enc(OP_MOVE_FROM_HIGH_RESULT, 4, 0, 0, 0);
        imem[5] = enc(OP_DIV64, 0, 1, 2, 0);
        imem[6] = enc(OP_MOVE_FROM_LOW_RESULT, 5, 0, 0, 0);
        imem[7] = enc(OP_MOVE_FROM_HIGH_RESULT, 6, 0, 0, 0);
        for (int k = 0; k < 4; k++) imem[8+k] = enc(OP_SD, 0, 0, k + 3, 'h60 + 8 * k);
        imem[12] = enc(OP_ADDI, 9, 0, 0, -3);
        imem[13] = enc(OP_MUL64, 0, 9, 2, 0);
        imem[14] = enc(OP_MOVE_FROM_LOW_RESULT, 10, 0, 0, 0);
        imem[15] = enc(OP_DIV32, 0, 9, 2, 0);
        imem[16] = enc(OP_MOVE_FROM_LOW_RESULT, 11, 0, 0, 0);
        imem[17] = enc(OP_SD, 0, 0, 10, 'h80);
        imem[18] = enc(OP_SD, 0, 0, 11, 'h88);
        do_reset;
        run(170, s);
        `CHECK("product low", 64'h15, dmem[12])
        `CHECK("product high", 64'h0, dmem[13])
        `CHECK("quotient", 64'h2, dmem[14])
        `CHECK("remainder", 64'h1, dmem[15])
        `CHECK("wide product low", 64'hFFFF_FFFF_FFFF_FFF7, dmem[16])
        `CHECK("word quotient", 64'hFFFF_FFFF_FFFF_FFFF, dmem[17])
        // Slips: fast 32-bit multiply 6, 64-bit divide 74, fast 64-bit multiply 7, 32-bit divide 42
        `CHECK("muldiv interlock", 129, s)
    endtask

    task automatic t_branch;
        int s;
        clear_mem;
        imem[0] = enc(OP_ADDI, 3, 0, 0, 1);
        imem[1] = enc(OP_BEQ, 0, 0, 0, 2);
        imem[2] = enc(OP_ADDI, 2, 0, 0, 7);
        imem[3] = enc(OP_ADDI, 3, 0, 0, 9);
        imem[4] = enc(OP_SD, 0, 0, 2, 'h80);
        imem[5] = enc(OP_SD, 0, 0, 3, 'h88);
        do_reset;
        run(30, s);
        `CHECK("delay slot", 64'h7, dmem[16])
        `CHECK("squashed word", 64'h1, dmem[17])
    endtask

    task automatic t_freeze;
        logic [63:0] a;
        int          s;
        do_reset;
        run(3, s);
        @(posedge mclk) ce <= 1'b0;
        @(negedge mclk) a = iaddr;
        repeat (3) @(negedge mclk);
        `CHECK("frozen fetch", a, iaddr)
        @(posedge mclk) ce <= 1'b1;
        repeat (2) @(negedge mclk);
        `CHECK("resumed fetch", a + 64'h4, iaddr)
        @(posedge mclk) rstn <= 1'b0;
        @(negedge mclk);
        `CHECK("reset fetch", 64'h0, iaddr)
        `CHECK("reset store", 1'b0, dwe)
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        close_out;
    end

    initial begin
        rstn = 1'b0;
        ce   = 1'b1;
        t_alu;
        t_load;
        t_muldiv;
        t_branch;
        t_freeze;
        close_out;
    end
endmodule
`default_nettype wire
